/* File: bench/crm_host.sv */
/* crm_host: host model issuing command-code register cycles.
   assumes CLK from the bench; one strobe per cycle. */
`timescale 1ns/1ps
module crm_host (
	input wire logic CLK,
	output logic WR,
	output logic RD,
	output logic [7:0] CMD,
	output logic [7:0] WDATA
);
	initial begin
		WR = 1'b0;
		RD = 1'b0;
		CMD = 8'h00;
		WDATA = 8'h00;
	end
	task acc(input logic w, input logic [7:0] c, input logic [7:0] d);
		WR = w;
		RD = !w;
		CMD = c;
		WDATA = d;
		@(posedge CLK);
		#1;
		WR = 1'b0;
		RD = 1'b0;
		// released lines show garbage, not the last byte
		CMD = ~c;
		WDATA = ~d;
	endtask : acc
endmodule : crm_host

/* File: bench/tb_top.sv */
/* tb_top: map register bench, host model plus routing checks.
   assumes crm_pkg and crm_channel_remap compiled first. */
`timescale 1ns/1ps
module tb_top;
	logic clk = 1'b0, rst_b = 1'b0, dev_b = 1'b1, wr, rd, done, rej;
	logic [7:0] cmd, wd, rdata, map;
	logic [3:0] on = 4'h0, len = 4'h0, pen;
	logic [55:0] pm = {14'h0AA4, 14'h0AA3, 14'h0AA2, 14'h0AA1}, lm;
	int err_count = 0, cmp_count = 0;
	initial begin
		forever #4 clk = ~clk;
	end
	crm_host u_host (.CLK(clk), .WR(wr), .RD(rd), .CMD(cmd), .WDATA(wd));
	crm_channel_remap u_dut (.CLK(clk), .RST_B(rst_b), .DEV_RESET_B(dev_b),
		.REG_WR(wr), .REG_RD(rd), .REG_CMD(cmd), .REG_WDATA(wd),
		.REG_RDATA(rdata), .MAP_WR_DONE(done), .MAP_WR_REJECT(rej),
		.PHYS_CH_ON(on), .LOG_EN(len), .PHYS_EN(pen), .PHYS_MEAS(pm),
		.LOG_MEAS(lm), .MAP_VALUE(map));
	task chk_byte(input logic [7:0] g, input logic [7:0] e);
		cmp_count++;
		if (g !== e) begin
			err_count++;
			$display("[ERR] %0t byte got %h want %h", $time, g, e);
		end
	endtask : chk_byte
	task chk_flags(input logic [1:0] g, input logic [1:0] e);
		cmp_count++;
		if (g !== e) begin
			err_count++;
			$display("[ERR] %0t pulses got %b want %b", $time, g, e);
		end
	endtask : chk_flags
	task chk_en(input logic [3:0] g, input logic [3:0] e);
		cmp_count++;
		if (g !== e) begin
			err_count++;
			$display("[ERR] %0t enables got %h want %h", $time, g, e);
		end
	endtask : chk_en
	task chk_meas(input logic [55:0] g, input logic [55:0] e);
		cmp_count++;
		if (g !== e) begin
			err_count++;
			$display("[ERR] %0t meas got %h want %h", $time, g, e);
		end
	endtask : chk_meas
	task route(input logic [7:0] m);
		logic [3:0] e;
		logic [55:0] x;
		for (int i = 0; i < 4; i++) begin
			e = 4'h0;
			e[m[2*i+:2]] = 1'b1;
			x[i*14+:14] = pm[m[2*i+:2]*14+:14];
			len = 4'h1 << i;
			repeat (2) @(posedge clk);
			#1;
			chk_en(pen, e);
		end
		chk_meas(lm, x);
		len = 4'h0;
	endtask : route
	task wmap(input logic [7:0] d, input logic ok, input logic [7:0] e);
		@(posedge clk);
		#1;
		u_host.acc(1'b1, crm_pkg::CMD_CH_MAP, d);
		chk_flags({done, rej}, {ok, !ok});
		// let an edge pass so the host lines are not driven twice at once
		@(posedge clk);
		#1;
		u_host.acc(1'b0, crm_pkg::CMD_CH_MAP, 8'h00);
		chk_byte(rdata, e);
		chk_byte(map, e);
		chk_flags({done, rej}, 2'h0);
	endtask : wmap
	task tally_and_finish;
		$display("comparisons %0d mismatches %0d", cmp_count, err_count);
		if (err_count == 0 && cmp_count > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask : tally_and_finish
	initial begin
		// tests need under 200 cycles; 2500 leaves ample margin
		#20000;
		err_count++;
		$display("[ERR] %0t watchdog expired", $time);
		tally_and_finish();
	end
	initial begin
		repeat (20) @(posedge clk);
		#1;
		rst_b = 1'b1;
		chk_byte(map, crm_pkg::MAP_RESET);
		route(8'hE4);
		$display("test reset done");
		wmap(8'h1B, 1'b1, 8'h1B);
		route(8'h1B);
		$display("test remap done");
		repeat (4) @(posedge clk); // detect-classify pass
		#1;
		on = 4'h4; // one channel still on
		wmap(8'h4E, 1'b0, 8'h1B);
		on = 4'h0;
		wmap(8'hE5, 1'b0, 8'h1B);
		@(posedge clk);
		#1;
		u_host.acc(1'b1, crm_pkg::CMD_DEV_RESET, 8'hE4);
		chk_flags({done, rej}, 2'h0);
		chk_byte(map, 8'h1B);
		@(posedge clk);
		#1;
		u_host.acc(1'b0, 8'h27, 8'h00);
		chk_byte(rdata, 8'h00);
		$display("test refuse done");
		dev_b = 1'b0;
		len = 4'hF;
		repeat (3) @(posedge clk);
		#1;
		chk_en(pen, 4'h0);
		chk_byte(map, 8'h1B);
		dev_b = 1'b1;
		repeat (2) @(posedge clk);
		#1;
		chk_en(pen, 4'hF);
		$display("test devreset done");
		rst_b = 1'b0;
		repeat (2) @(posedge clk);
		#1;
		rst_b = 1'b1;
		chk_byte(map, crm_pkg::MAP_RESET);
		chk_byte(rdata, 8'h00);
		route(8'hE4);
		$display("test por done");
		tally_and_finish();
	end
endmodule : tb_top

/* File: design/crm_channel_remap.sv */
/*
 * crm_channel_remap: map register of one four-channel group and the
 * routing of per-channel controls and measurements through it.
 * Assumes a command-code register port already decoded from the serial
 * bus, one strobe per byte, synchronous to CLK. RST_B is power-on reset.
 */
`timescale 1ns/1ps

module crm_channel_remap #(
	parameter int MEAS_W = 14
) (
	input wire logic CLK,
	input wire logic RST_B,
	input wire logic DEV_RESET_B,
	input wire logic REG_WR,
	input wire logic REG_RD,
	input wire logic [7:0] REG_CMD,
	input wire logic [7:0] REG_WDATA,
	output logic [7:0] REG_RDATA,
	output logic MAP_WR_DONE,
	output logic MAP_WR_REJECT,
	input wire logic [crm_pkg::NUM_CH-1:0] PHYS_CH_ON,
	input wire logic [crm_pkg::NUM_CH-1:0] LOG_EN,
	output logic [crm_pkg::NUM_CH-1:0] PHYS_EN,
	input wire logic [crm_pkg::NUM_CH*MEAS_W-1:0] PHYS_MEAS,
	output logic [crm_pkg::NUM_CH*MEAS_W-1:0] LOG_MEAS,
	output logic [crm_pkg::MAP_W-1:0] MAP_VALUE
);
	localparam int N = crm_pkg::NUM_CH;
	localparam int FW = crm_pkg::FIELD_W;

	// slice index math is int wide; keep words to a sane width
	if (MEAS_W < 1 || MEAS_W > 32) begin : g_bad_meas_w
		$error("MEAS_W out of range");
	end

	// true when two fields carry the same code
	function automatic logic has_dup(input logic [crm_pkg::MAP_W-1:0] m);
		logic d;
		d = 1'b0;
		for (int i = 0; i < N; i++) begin
			for (int j = i + 1; j < N; j++) begin
				if (m[i*FW +: FW] == m[j*FW +: FW]) begin
					d = 1'b1;
				end
			end
		end
		return d;
	endfunction : has_dup

	logic [crm_pkg::MAP_W-1:0] map_q, map_d;
	logic [7:0] rdata_q, rdata_d;
	logic done_q, done_d, rej_q, rej_d;
	logic [N-1:0] phys_en_q, phys_en_d;
	logic [N*MEAS_W-1:0] meas_q, meas_d;
	logic map_wr, wr_ok;

	assign map_wr = REG_WR && (REG_CMD == crm_pkg::CMD_CH_MAP);
	// codes are only 2 bits wide, so no field can name the other group
	assign wr_ok = map_wr && (PHYS_CH_ON == '0)
		&& !has_dup(REG_WDATA);

	always_comb begin
		map_d = map_q;
		if (wr_ok) begin
			map_d = REG_WDATA;
		end
		// neither DEV_RESET_B nor the reset command touch the map
		done_d = wr_ok;
		// a dropped write still pulses, so the host can see the refusal
		rej_d = map_wr && !wr_ok;
		// a read beside a write returns the map as it was before
		rdata_d = rdata_q;
		if (REG_RD) begin
			rdata_d = (REG_CMD == crm_pkg::CMD_CH_MAP) ? map_q : 8'h00;
		end
	end

	// routing: logical i drives physical map field i
	always_comb begin
		phys_en_d = '0;
		meas_d = '0;
		for (int i = 0; i < N; i++) begin
			if (LOG_EN[i]) begin
				phys_en_d[map_q[i*FW +: FW]] = 1'b1;
			end
			meas_d[i*MEAS_W +: MEAS_W] =
				PHYS_MEAS[map_q[i*FW +: FW]*MEAS_W +: MEAS_W];
		end
		// a device reset turns every channel off, not the map
		if (!DEV_RESET_B) begin
			phys_en_d = '0;
		end
	end

	// register group: map, read data and the write answer pulses
	always_ff @(posedge CLK) begin
		if (!RST_B) begin
			map_q <= crm_pkg::MAP_RESET;
			rdata_q <= 8'h00;
			done_q <= 1'b0;
			rej_q <= 1'b0;
		end else begin
			map_q <= map_d;
			rdata_q <= rdata_d;
			done_q <= done_d;
			rej_q <= rej_d;
		end
	end

	// routing group: enables and measurements through the current map
	always_ff @(posedge CLK) begin
		if (!RST_B) begin
			phys_en_q <= '0;
			meas_q <= '0;
		end else begin
			phys_en_q <= phys_en_d;
			meas_q <= meas_d;
		end
	end

	assign REG_RDATA = rdata_q;
	assign MAP_WR_DONE = done_q;
	assign MAP_WR_REJECT = rej_q;
	assign PHYS_EN = phys_en_q;
	assign LOG_MEAS = meas_q;
	assign MAP_VALUE = map_q;

	chk_map_por_value: assert property (@(posedge CLK)
		!RST_B |=> map_q == crm_pkg::MAP_RESET)
		else $error("map not identity after power-on");

	chk_write_while_on: assert property (@(posedge CLK)
		disable iff (!RST_B)
		map_wr && (PHYS_CH_ON != '0) |=> $stable(map_q) && MAP_WR_REJECT)
		else $error("map changed while a channel was on");

	chk_dup_write_drop: assert property (@(posedge CLK)
		disable iff (!RST_B)
		map_wr && has_dup(REG_WDATA) |=> $stable(map_q) && MAP_WR_REJECT)
		else $error("duplicate-code write altered map");

	chk_good_write_take: assert property (@(posedge CLK)
		disable iff (!RST_B)
		map_wr && (PHYS_CH_ON == '0) && !has_dup(REG_WDATA)
		|=> map_q == $past(REG_WDATA) && MAP_WR_DONE)
		else $error("valid map write not stored");

	chk_reset_pin_keep: assert property (@(posedge CLK)
		disable iff (!RST_B)
		!DEV_RESET_B && !map_wr |=> $stable(map_q) && PHYS_EN == '0)
		else $error("device reset disturbed map");

	chk_map_unique: assert property (@(posedge CLK)
		disable iff (!RST_B)
		!has_dup(map_q))
		else $error("map holds a repeated code");

	chk_enable_route: assert property (@(posedge CLK)
		disable iff (!RST_B)
		LOG_EN[0] && DEV_RESET_B
		|=> PHYS_EN[$past(map_q[crm_pkg::FIELD_LSB_LOG1 +: FW])])
		else $error("logical 1 enable not on mapped channel");

	chk_meas_route: assert property (@(posedge CLK)
		disable iff (!RST_B)
		1'b1 |=> LOG_MEAS[N*MEAS_W-1 -: MEAS_W] ==
		$past(PHYS_MEAS[map_q[crm_pkg::FIELD_LSB_LOG4 +: FW]*MEAS_W
		+: MEAS_W]))
		else $error("logical 4 measurement from wrong channel");

	chk_read_back: assert property (@(posedge CLK)
		disable iff (!RST_B)
		REG_RD && REG_CMD == crm_pkg::CMD_CH_MAP
		|=> REG_RDATA == $past(map_q))
		else $error("map read-back wrong");

	chk_read_other_zero: assert property (@(posedge CLK)
		disable iff (!RST_B)
		REG_RD && REG_CMD != crm_pkg::CMD_CH_MAP |=> REG_RDATA == 8'h00)
		else $error("unmapped read not zero");

	chk_rdata_hold: assert property (@(posedge CLK)
		disable iff (!RST_B)
		!REG_RD |=> $stable(REG_RDATA))
		else $error("read data moved without a read");

	chk_pulse_excl: assert property (@(posedge CLK)
		disable iff (!RST_B)
		!(MAP_WR_DONE && MAP_WR_REJECT))
		else $error("write both accepted and refused");

	chk_map_only_on_write: assert property (@(posedge CLK)
		disable iff (!RST_B)
		!wr_ok |=> $stable(map_q))
		else $error("map changed without an accepted write");

	chk_devcmd_keep: assert property (@(posedge CLK)
		disable iff (!RST_B)
		REG_WR && REG_CMD == crm_pkg::CMD_DEV_RESET
		|=> $stable(map_q) && !MAP_WR_DONE && !MAP_WR_REJECT)
		else $error("reset command disturbed map");

	// every logical channel, not only the two corners checked above
	for (genvar gi = 0; gi < N; gi++) begin : g_route_chk
		chk_en_route_each: assert property (@(posedge CLK)
			disable iff (!RST_B)
			LOG_EN[gi] && DEV_RESET_B
			|=> PHYS_EN[$past(map_q[gi*FW +: FW])])
			else $error("logical enable not on mapped channel");

		chk_meas_route_each: assert property (@(posedge CLK)
			disable iff (!RST_B)
			1'b1 |=> LOG_MEAS[gi*MEAS_W +: MEAS_W] ==
			$past(PHYS_MEAS[map_q[gi*FW +: FW]*MEAS_W +: MEAS_W]))
			else $error("logical measurement from wrong channel");
	end
endmodule : crm_channel_remap

/* File: design/crm_pkg.sv */
/*
 * crm_pkg: constants for the logical-to-physical channel map of one
 * four-channel group. Assumes the host reaches the register through the
 * device's command-code register port.
 */
package crm_pkg;
	localparam int NUM_CH = 4;
	localparam int FIELD_W = 2;
	localparam int MAP_W = NUM_CH * FIELD_W;
	localparam logic [7:0] CMD_CH_MAP = 8'h26;
	localparam logic [7:0] CMD_DEV_RESET = 8'h1A;
	localparam logic [MAP_W-1:0] MAP_RESET = 8'hE4;
	// field of logical channel n (1-based) sits at bits 2n-1 .. 2n-2
	localparam int FIELD_LSB_LOG1 = 0;
	localparam int FIELD_LSB_LOG4 = 6;
endpackage : crm_pkg
